// [mise_pkg.sv]
// package: constants and carrier types for the instruction subset executor
package mise_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 10;
    localparam int REG_ADDR_W = 6;
    localparam int BIT_IDX_W = 3;
    localparam int SP_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [9:0] PC_RESET = 10'h000;
    localparam logic [2:0] SP_RESET = 3'h0;
    localparam logic [7:0] TABLE_HIGH_POINTER_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam int CALL_CYCLES = 2;
    localparam int TABLE_HIGH_POINTER_PC_LSB = 8;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_AND_IMM,
        OP_BIT_SET,
        OP_SKIP_CLR,
        OP_SKIP_SET,
        OP_CALL_IND,
        OP_ACC_CLR
    } mise_op_e;

    typedef struct packed {
        logic valid;
        mise_op_e op;
        logic [7:0] imm;
        logic [5:0] reg_addr;
        logic [2:0] bit_idx;
    } mise_instr_s;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] data;
    } mise_reg_wr_s;
endpackage : mise_pkg

// [mise_bit_unit.sv]
// module: register bit test and bit set helper
`timescale 1ns/1ps
module mise_bit_unit #(
    parameter int DATA_W = 8
) (
    input wire logic [DATA_W-1:0] reg_val_in,
    input wire logic [2:0] bit_idx_in,
    output logic bit_out,
    output logic [DATA_W-1:0] set_val_out
);
    initial begin
        if (DATA_W != 8) $error("mise_bit_unit needs 8-bit data");
    end

    always_comb begin
        bit_out = reg_val_in[bit_idx_in];
        set_val_out = reg_val_in;
        set_val_out[bit_idx_in] = 1'b1;
    end
endmodule : mise_bit_unit

// [mise_core.sv]
// module: executor for and-immediate, bit set, test-skip, call, clear
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - and-immediate ANDs the accumulator with imm, updates only zero flag, one cycle.
// - bit-set forces the chosen bit of register 0..63 to one, no flags, one cycle.
// - skip-if-clear discards the fetched next instruction when the bit is 0.
// - skip-if-set discards the fetched next instruction when the bit is 1.
// - indirect call pushes pc plus one onto the stack and takes two cycles.
// - indirect call loads pointer bits 1:0 into pc 9:8 and accumulator into 7:0.
// - accumulator clear writes zero and sets the zero flag, one cycle.
// - the table high pointer supplies pc 9:8 of the call target from its bits 1:0.
////////////////////////////////////////////////////////////////////////////
module mise_core #(
    parameter int STACK_DEPTH = mise_pkg::STACK_DEPTH
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire mise_pkg::mise_instr_s instr_in,
    input wire logic [9:0] pc_in,
    input wire logic [7:0] reg_rd_data_in,
    input wire logic table_high_pointer_we_in,
    input wire logic [7:0] table_high_pointer_data_in,
    output logic [5:0] reg_rd_addr_out,
    output mise_pkg::mise_reg_wr_s reg_wr_out,
    output logic [7:0] accumulator_out,
    output logic zero_flag_out,
    output logic [7:0] table_high_pointer_out,
    output logic pc_load_out,
    output logic [9:0] pc_load_val_out,
    output logic flush_out,
    output logic stall_out,
    output logic push_out,
    output logic [9:0] push_data_out,
    output logic [2:0] stack_ptr_out,
    output logic [9:0] stack_top_out
);
    initial begin
        if (STACK_DEPTH < 1 || STACK_DEPTH > 8)
            $error("stack depth must be 1 to 8");
    end

    // widths below are wired into the port list and the datapath
    initial begin
        if (mise_pkg::DATA_W != 8) begin
            $error("data width must be 8");
        end
        if (mise_pkg::PC_W != 10) begin
            $error("program counter width must be 10");
        end
        if (mise_pkg::REG_ADDR_W != 6) begin
            $error("register address width must be 6");
        end
        if (mise_pkg::BIT_IDX_W != 3) begin
            $error("bit index width must be 3");
        end
        if (mise_pkg::SP_W != 3) begin
            $error("stack pointer width must be 3");
        end
        if (mise_pkg::TABLE_HIGH_POINTER_PC_LSB + 2 != mise_pkg::PC_W) begin
            $error("pointer bits must land on the top of the pc");
        end
        if (mise_pkg::CALL_CYCLES != 2) begin
            $error("call sequencing assumes two cycles");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] acc;
        logic zero;
        logic [7:0] table_high_pointer;
        logic [5:0] rd_addr;
        mise_pkg::mise_reg_wr_s wr;
        logic pc_load;
        logic [9:0] pc_val;
        logic flush;
        logic stall;
        logic call_busy;
        logic push;
        logic [9:0] push_data;
        logic [2:0] sp;
        logic [9:0] top;
    } mise_state_s;

    mise_state_s st_q;
    mise_state_s st_d;
    logic [9:0] stack_q [STACK_DEPTH];
    logic test_bit;
    logic [7:0] set_val;
    logic [7:0] and_res;

    mise_bit_unit #(.DATA_W(8)) u_bit (
        .reg_val_in(reg_rd_data_in),
        .bit_idx_in(instr_in.bit_idx),
        .bit_out(test_bit),
        .set_val_out(set_val)
    );

    function automatic logic is_op(mise_pkg::mise_instr_s i,
                                   mise_pkg::mise_op_e o);
        is_op = i.valid && i.op == o;
    endfunction : is_op

    assign and_res = st_q.acc & instr_in.imm;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        st_d.rd_addr = instr_in.reg_addr;
        st_d.wr = '0;
        st_d.pc_load = 1'b0;
        st_d.flush = 1'b0;
        st_d.stall = 1'b0;
        st_d.push = 1'b0;
        st_d.call_busy = 1'b0;
        if (table_high_pointer_we_in) begin
            st_d.table_high_pointer = table_high_pointer_data_in;
        end
        if (!st_q.call_busy) begin
            case (instr_in.valid ? instr_in.op : mise_pkg::OP_NONE)
                mise_pkg::OP_AND_IMM: begin
                    st_d.acc = and_res;
                    st_d.zero = (and_res == 8'h00);
                end
                mise_pkg::OP_BIT_SET: begin
                    st_d.wr.we = 1'b1;
                    st_d.wr.addr = instr_in.reg_addr;
                    st_d.wr.data = set_val;
                end
                mise_pkg::OP_SKIP_CLR: begin
                    st_d.flush = !test_bit;
                end
                mise_pkg::OP_SKIP_SET: begin
                    st_d.flush = test_bit;
                end
                mise_pkg::OP_CALL_IND: begin
                    st_d.push = 1'b1;
                    st_d.push_data = 10'(pc_in + 10'h001);
                    st_d.stall = 1'b1;
                    st_d.call_busy = 1'b1;
                    st_d.pc_load = 1'b1;
                    st_d.pc_val = {st_q.table_high_pointer[1:0], st_q.acc};
                    st_d.flush = 1'b1;
                    st_d.top = 10'(pc_in + 10'h001);
                    st_d.sp = 3'(st_q.sp + 3'h1);
                end
                mise_pkg::OP_ACC_CLR: begin
                    st_d.acc = 8'h00;
                    st_d.zero = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (is_op(instr_in, mise_pkg::OP_NONE)) begin
            st_d.rd_addr = st_q.rd_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
            st_q.acc <= mise_pkg::ACC_RESET;
            st_q.zero <= mise_pkg::ZERO_RESET;
            st_q.table_high_pointer <= mise_pkg::TABLE_HIGH_POINTER_RESET;
            st_q.sp <= mise_pkg::SP_RESET;
            st_q.pc_val <= mise_pkg::PC_RESET;
            st_q.push_data <= mise_pkg::PC_RESET;
            st_q.top <= mise_pkg::PC_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one write enable per stack entry, pointer wraps over the depth
    genvar g;
    generate
        for (g = 0; g < STACK_DEPTH; g++) begin : g_stack
            always_ff @(posedge ref_clk_in) begin
                if (st_d.push &&
                    (3'(g) == 3'(int'(st_q.sp) % STACK_DEPTH))) begin
                    stack_q[g] <= st_d.push_data;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////

    assign reg_rd_addr_out = instr_in.reg_addr;
    assign reg_wr_out = st_q.wr;
    assign accumulator_out = st_q.acc;
    assign zero_flag_out = st_q.zero;
    assign table_high_pointer_out = st_q.table_high_pointer;
    assign pc_load_out = st_q.pc_load;
    assign pc_load_val_out = st_q.pc_val;
    assign flush_out = st_q.flush;
    assign stall_out = st_q.stall;
    assign push_out = st_q.push;
    assign push_data_out = st_q.push_data;
    assign stack_ptr_out = st_q.sp;
    assign stack_top_out = st_q.top;
endmodule : mise_core

// [mise_rf_model.sv]
// register file model on the far side of the executor
`timescale 1ns/1ps
module mise_rf_model (
    input wire logic ref_clk_in,
    input wire mise_pkg::mise_reg_wr_s wr_in,
    input wire logic [5:0] addr_in,
    output logic [7:0] data_out
);
    logic [7:0] mem_q [64];
    // preload: entry a holds a*37
    initial begin
        for (int i = 0; i < 64; i++) mem_q[i] = 8'(i * 37);
    end
    assign data_out = mem_q[addr_in];
    always @(posedge ref_clk_in) begin
        if (wr_in.we) mem_q[wr_in.addr] <= wr_in.data;
    end
endmodule : mise_rf_model

// [mise_core_props.sv]
// assertions for the instruction subset executor
`timescale 1ns/1ps
module mise_core_props (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire mise_pkg::mise_instr_s instr_in,
    input wire logic [9:0] pc_in,
    input wire logic [7:0] reg_rd_data_in,
    input wire mise_pkg::mise_reg_wr_s reg_wr_out,
    input wire logic [7:0] accumulator_out,
    input wire logic zero_flag_out,
    input wire logic [7:0] table_high_pointer_out,
    input wire logic pc_load_out,
    input wire logic [9:0] pc_load_val_out,
    input wire logic flush_out,
    input wire logic stall_out,
    input wire logic push_out,
    input wire logic [9:0] push_data_out,
    input wire logic [2:0] stack_ptr_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    wire tk = instr_in.valid && !stall_out;
    wire sel = reg_rd_data_in[instr_in.bit_idx];
    wire [9:0] tgt = {table_high_pointer_out[1:0], accumulator_out};
    wire t_and = tk && instr_in.op == mise_pkg::OP_AND_IMM;
    wire t_set = tk && instr_in.op == mise_pkg::OP_BIT_SET;
    wire t_skc = tk && instr_in.op == mise_pkg::OP_SKIP_CLR;
    wire t_sks = tk && instr_in.op == mise_pkg::OP_SKIP_SET;
    wire t_call = tk && instr_in.op == mise_pkg::OP_CALL_IND;
    wire t_clr = tk && instr_in.op == mise_pkg::OP_ACC_CLR;
    AST_AND: assert property (t_and |=>
        accumulator_out == ($past(accumulator_out) & $past(instr_in.imm))
        && zero_flag_out == (accumulator_out == 8'h00) && !reg_wr_out.we)
        else $error("and result or zero flag wrong");
    AST_BSET: assert property (t_set |=> reg_wr_out.we &&
        reg_wr_out.addr == $past(instr_in.reg_addr) && reg_wr_out.data ==
        ($past(reg_rd_data_in) | (8'h01 << $past(instr_in.bit_idx))))
        else $error("bit set write wrong");
    AST_BSET_FLAG: assert property (t_set |=>
        $stable(zero_flag_out) && $stable(accumulator_out))
        else $error("bit set changed flags");
    AST_SKC: assert property (t_skc |=> flush_out != $past(sel))
        else $error("skip if clear wrong");
    AST_SKS: assert property (t_sks |=> flush_out == $past(sel))
        else $error("skip if set wrong");
    AST_CALL: assert property (t_call |=> push_out && stall_out &&
        push_data_out == $past(pc_in) + 10'h001 ##1 !push_out && !stall_out)
        else $error("call push or length wrong");
    AST_TGT: assert property (t_call |=>
        pc_load_out && pc_load_val_out == $past(tgt))
        else $error("call target wrong");
    AST_CLR: assert property (t_clr |=>
        accumulator_out == 8'h00 && zero_flag_out)
        else $error("clear wrong");
    AST_SP: assert property (t_call |=>
        stack_ptr_out == $past(stack_ptr_out) + 3'h1)
        else $error("stack pointer wrong");
    cover property (t_call);
    cover property (flush_out && !stall_out);
    cover property (reg_wr_out.we);
endmodule : mise_core_props
bind mise_core mise_core_props u_props (.ref_clk_in, .sys_rst_in, .instr_in,
    .pc_in, .reg_rd_data_in, .reg_wr_out, .accumulator_out, .zero_flag_out,
    .table_high_pointer_out, .pc_load_out, .pc_load_val_out, .flush_out,
    .stall_out, .push_out, .push_data_out, .stack_ptr_out);

// [mise_core_bench.sv]
// self-checking bench for the instruction subset executor
`timescale 1ns/1ps
module mise_core_bench;
    typedef struct {
        mise_pkg::mise_op_e op;
        logic [7:0] imm;
        logic [5:0] ra;
        logic [2:0] bi;
        logic fl, we, z;
        logic [7:0] wd;
    } mise_row_s;
    logic clk = 1'h0, rst = 1'h1, twe = 1'h0, z, pl, fl, st, pu;
    mise_pkg::mise_instr_s ins = '0;
    mise_pkg::mise_reg_wr_s wr;
    logic [9:0] pc = 10'h000, plv, pd, top;
    logic [7:0] td = 8'h00, rd, acc, tp;
    logic [5:0] ra;
    logic [2:0] sp;
    int miscompares = 0, checked = 0;
    mise_row_s rows [8] = '{
        '{mise_pkg::OP_BIT_SET, 8'h00, 6'h02, 3'h0, 0, 1, 0, 8'h4B},
        '{mise_pkg::OP_BIT_SET, 8'h00, 6'h03, 3'h7, 0, 1, 0, 8'hEF},
        '{mise_pkg::OP_SKIP_CLR, 8'h00, 6'h05, 3'h1, 1, 0, 0, 8'h00},
        '{mise_pkg::OP_SKIP_CLR, 8'h00, 6'h05, 3'h0, 0, 0, 0, 8'h00},
        '{mise_pkg::OP_SKIP_SET, 8'h00, 6'h05, 3'h3, 1, 0, 0, 8'h00},
        '{mise_pkg::OP_SKIP_SET, 8'h00, 6'h05, 3'h2, 0, 0, 0, 8'h00},
        '{mise_pkg::OP_AND_IMM, 8'hFF, 6'h00, 3'h0, 0, 0, 1, 8'h00},
        '{mise_pkg::OP_ACC_CLR, 8'h00, 6'h00, 3'h0, 0, 0, 1, 8'h00}};
    mise_core u_mise_core (.ref_clk_in(clk), .sys_rst_in(rst),
        .instr_in(ins), .pc_in(pc), .reg_rd_data_in(rd), .table_high_pointer_we_in(twe),
        .table_high_pointer_data_in(td), .reg_rd_addr_out(ra), .reg_wr_out(wr),
        .accumulator_out(acc), .zero_flag_out(z),
        .table_high_pointer_out(tp), .pc_load_out(pl),
        .pc_load_val_out(plv), .flush_out(fl), .stall_out(st),
        .push_out(pu), .push_data_out(pd), .stack_ptr_out(sp),
        .stack_top_out(top));
    mise_rf_model u_mise_rf_model (.ref_clk_in(clk), .wr_in(wr),
        .addr_in(ra), .data_out(rd));
    always #50 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic do_reset();
        rst = 1'h1;
        repeat (4) @(negedge clk);
        rst = 1'h0;
    endtask : do_reset
    initial begin
        repeat (200) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            ins = '{1'h1, rows[i].op, rows[i].imm, rows[i].ra, rows[i].bi};
            @(negedge clk);
            ins.valid = 1'h0;
            chk(16'(fl), 16'(rows[i].fl));
            chk(16'(wr.we), 16'(rows[i].we));
            if (rows[i].we) chk(16'(wr.data), 16'(rows[i].wd));
            chk(16'(z), 16'(rows[i].z));
            chk(16'(acc), 16'h0000);
            @(negedge clk);
        end
        do_reset();
        chk(16'(z), 16'h0000);
        ins = '{1'h1, mise_pkg::OP_ACC_CLR, 8'h00, 6'h00, 3'h0};
        twe = 1'h1;
        td = 8'hF6;
        pc = 10'h3FF;
        @(negedge clk);
        chk(16'(z), 16'h0001);
        chk(16'(tp), 16'h00F6);
        twe = 1'h0;
        ins.op = mise_pkg::OP_CALL_IND;
        @(negedge clk);
        chk({pu, st, pl, 3'h0, pd}, 16'hE000);
        chk(16'(plv), 16'h0200);
        chk(16'(sp), 16'h0001);
        // call's second cycle: this bit set must be ignored
        ins = '{1'h1, mise_pkg::OP_BIT_SET, 8'h00, 6'h07, 3'h0};
        @(negedge clk);
        chk({pu, st, wr.we}, 16'h0000);
        ins.op = mise_pkg::OP_CALL_IND;
        pc = 10'h0A0;
        @(negedge clk);
        ins.valid = 1'h0;
        chk(16'(pd), 16'h00A1);
        chk(16'(sp), 16'h0002);
        chk(16'(top), 16'h00A1);
        end_of_test();
    end
endmodule : mise_core_bench
